// ---- cwc_top.v ----
// APB register slice for clock reference, watchdog, dither and bus current limit.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_top #(
    parameter [31:0] PIN_P0 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER0_MS,
    parameter [31:0] PIN_P1 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER1_MS,
    parameter [31:0] PIN_P2 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER2_MS,
    parameter [31:0] PIN_P3 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER3_MS,
    parameter [31:0] BUS_P0 = `CWC_CLK_HZ * `CWC_BUS_PER0_S,
    parameter [31:0] BUS_P1 = `CWC_CLK_HZ * `CWC_BUS_PER1_S,
    parameter [31:0] BUS_P2 = `CWC_CLK_HZ * `CWC_BUS_PER2_S,
    parameter [31:0] BUS_P3 = `CWC_CLK_HZ * `CWC_BUS_PER3_S
)
(
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire tickle_pin_i,
    output reg [10:0] ext_ref_khz_o,
    output reg ext_ref_sel_o,
    output reg switching_clock_dither_o,
    output reg ilim_active_o,
    output reg [21:0] ilim_ua_o,
    output reg wdt_fault_o,
    output reg outputs_hiz_o,
    output reg irq_o
);
    reg [31:0] system_setup_two;
    reg [31:0] peripheral_setup_one;
    reg wdt_latched;
    reg [1:0] irq_stat;
    reg [1:0] irq_mask;
    reg tickle_pin_q;
    reg bus_tickle;
    reg [31:0] next_prdata;
    reg next_slverr;
    wire [21:0] lut_ua;
    wire wdt_expire;
    // The access cycle before pready launches the answer; the next one completes it.
    wire acc = psel_i && penable_i && pready_o;
    wire launch = psel_i && penable_i && !pready_o;
    wire wr = acc && pwrite_i;
    wire lane0 = pstrb_i[0];
    wire hit_sys2 = paddr_i == `CWC_SYS2_ADDR;
    wire hit_peri1 = paddr_i == `CWC_PERI1_ADDR;
    wire hit_fault = paddr_i == `CWC_FAULT_ADDR;
    wire hit_tickle = paddr_i == `CWC_TICKLE_ADDR;
    wire hit_stat = paddr_i == `CWC_IRQ_STAT_ADDR;
    wire hit_mask = paddr_i == `CWC_IRQ_MASK_ADDR;
    wire wr_sys2 = wr && hit_sys2;
    wire wr_peri1 = wr && hit_peri1;
    wire wr_tickle = wr && hit_tickle;
    wire wr_stat = wr && hit_stat && lane0;
    wire wr_mask = wr && hit_mask && lane0;
    wire [31:0] wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    // A partial write keeps the byte lanes whose strobe is low.
    wire [31:0] sys2_merged = (system_setup_two & ~wmask) | (pwdata_i & wmask);
    wire [31:0] peri1_merged = (peripheral_setup_one & ~wmask) | (pwdata_i & wmask);
    // Field views of the two setup registers.
    wire outside_watchdog_on = system_setup_two[`CWC_WDT_ON_BIT];
    wire watchdog_fault_response = system_setup_two[`CWC_WDT_FAULT_RESP_BIT];
    wire [1:0] tickle_period_sel = system_setup_two[`CWC_TICKLE_PER_LSB +: 2];
    wire [2:0] ext_clk_code = system_setup_two[`CWC_EXT_CLK_LSB +: 3];
    wire [1:0] clk_src_code = system_setup_two[`CWC_CLK_SRC_LSB +: 2];
    wire [3:0] ilim_code = peripheral_setup_one[`CWC_ILIM_LSB +: 4];
    wire ilim_on = peripheral_setup_one[`CWC_ILIM_ON_BIT];
    wire dither_off = peripheral_setup_one[`CWC_DITHER_OFF_BIT];
    wire tickle_src = system_setup_two[`CWC_TICKLE_SRC_BIT];
    wire pin_edge = tickle_pin_i && !tickle_pin_q;
    // With source bit zero, any write to the tickle address counts; data are ignored.
    wire tickle = tickle_src ? pin_edge : bus_tickle;
    // The wipe is a command, never stored, so a later write cannot apply it again.
    wire wipe = wr && hit_fault && lane0 && pwdata_i[0];
    wire [1:0] stat_clear = wr_stat ? pwdata_i[1:0] : 2'h0;

    cwc_wdt #(
        .PIN_P0(PIN_P0), .PIN_P1(PIN_P1), .PIN_P2(PIN_P2), .PIN_P3(PIN_P3),
        .BUS_P0(BUS_P0), .BUS_P1(BUS_P1), .BUS_P2(BUS_P2), .BUS_P3(BUS_P3)
    ) u_wdt (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(outside_watchdog_on),
        .source_i(tickle_src),
        .period_i(tickle_period_sel),
        .tickle_i(tickle),
        .expire_o(wdt_expire)
    );

    cwc_ilim_lut u_lut (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .code_i(ilim_code),
        .limit_ua_o(lut_ua)
    );

    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (paddr_i)
            `CWC_SYS2_ADDR: next_prdata = system_setup_two;
            `CWC_PERI1_ADDR: next_prdata = peripheral_setup_one;
            `CWC_FAULT_ADDR: next_prdata = {30'h0000_0000, wdt_latched, 1'b0};
            `CWC_TICKLE_ADDR: next_prdata = 32'h0000_0000;
            `CWC_IRQ_STAT_ADDR: next_prdata = {30'h0000_0000, irq_stat};
            `CWC_IRQ_MASK_ADDR: next_prdata = {30'h0000_0000, irq_mask};
            default: next_slverr = 1'b1;
        endcase
    end

    // One wait state: pready rises after the first access cycle and stands for one cycle.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_o <= 1'b0;
        end
        else
        begin
            pready_o <= launch;
        end
    end

    // Read data stand only with pready, so a late sample sees zero.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (launch && !pwrite_i)
        begin
            prdata_o <= next_prdata;
        end
        else
        begin
            prdata_o <= 32'h0000_0000;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pslverr_o <= 1'b0;
        end
        else if (launch)
        begin
            pslverr_o <= next_slverr;
        end
        else
        begin
            pslverr_o <= 1'b0;
        end
    end

    // Reserved bits are kept as written and steer nothing.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            system_setup_two <= `CWC_SYS2_RST;
        end
        else if (wr_sys2)
        begin
            system_setup_two <= sys2_merged;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            peripheral_setup_one <= `CWC_PERI1_RST;
        end
        else if (wr_peri1)
        begin
            peripheral_setup_one <= peri1_merged;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_mask <= 2'h0;
        end
        else if (wr_mask)
        begin
            irq_mask <= pwdata_i[1:0];
        end
    end

    // The pin is compared with its last sample, so only a rising edge tickles.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            tickle_pin_q <= 1'b0;
        end
        else
        begin
            tickle_pin_q <= tickle_pin_i;
        end
    end

    // A bus tickle is a one-cycle pulse after the write is accepted.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            bus_tickle <= 1'b0;
        end
        else
        begin
            bus_tickle <= wr_tickle;
        end
    end

    // A new expiry in the wiping cycle wins, so no missed tickle is ever lost.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            wdt_latched <= 1'b0;
        end
        else if (wdt_expire && watchdog_fault_response)
        begin
            wdt_latched <= 1'b1;
        end
        else if (wipe)
        begin
            wdt_latched <= 1'b0;
        end
    end

    // Sticky status, cleared by writing one; a new event in the clearing cycle wins.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_stat <= 2'h0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~stat_clear) | {1'b0, wdt_expire};
        end
    end

    // Every output below is registered: the first five from the decoded fields, the last three from fault and status.
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_ref_khz_o <= 11'h008;
        end
        else
        begin
            ext_ref_khz_o <= 11'h008 << ext_clk_code;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_ref_sel_o <= 1'b0;
        end
        else
        begin
            ext_ref_sel_o <= clk_src_code == `CWC_CLK_SRC_EXT;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            switching_clock_dither_o <= 1'b0;
        end
        else
        begin
            switching_clock_dither_o <= !dither_off;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ilim_active_o <= 1'b0;
        end
        else
        begin
            ilim_active_o <= ilim_on;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ilim_ua_o <= 22'h00_0000;
        end
        else
        begin
            ilim_ua_o <= ilim_on ? lut_ua : 22'h00_0000;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            wdt_fault_o <= 1'b0;
        end
        else
        begin
            wdt_fault_o <= wdt_latched || irq_stat[0];
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            outputs_hiz_o <= 1'b0;
        end
        else
        begin
            outputs_hiz_o <= wdt_latched;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end
endmodule

// ---- cwc_defs.vh ----
// Constants for the clock, watchdog and bus current configuration block.
// Notes on behaviour
// - External clock code 0..7 selects 8 kHz doubling up to 1024 kHz.
// - Watchdog supervision runs only while its enable bit is one.
// - Period code gives 100/200/500/1000 ms on pin, 1/2/5/10 s on bus.
// - Source bit zero takes tickles as bus writes, one takes the pin.
// - Missed tickle reports only when response bit zero; one latches and floats outputs.
// - Dither active when disable bit zero; bit resets to one.
// - Current limit codes 0..13 map to 0.078125 A up to 3.75 A.
// - Current limit enforced only while the limit enable bit is one.
// - External clock used as reference only when clock source code is 3.
// - Writing one to fault wipe clears latched faults; the bit self-clears.
`ifndef CWC_DEFS_VH
`define CWC_DEFS_VH
`define CWC_SYS2_IDX 8'hA8
`define CWC_PERI1_IDX 8'hAA
`define CWC_SYS2_ADDR 12'h2A0
`define CWC_PERI1_ADDR 12'h2A8
`define CWC_FAULT_ADDR 12'h300
`define CWC_TICKLE_ADDR 12'h304
`define CWC_IRQ_STAT_ADDR 12'h308
`define CWC_IRQ_MASK_ADDR 12'h30C
`define CWC_SYS2_RST 32'h0000_0000
`define CWC_PERI1_RST 32'h4000_0000
`define CWC_WDT_FAULT_RESP_BIT 0
`define CWC_TICKLE_SRC_BIT 1
`define CWC_TICKLE_PER_LSB 2
`define CWC_WDT_ON_BIT 4
`define CWC_EXT_CLK_LSB 5
`define CWC_EXT_CLK_EN_BIT 8
`define CWC_CLK_SRC_LSB 9
`define CWC_CLK_SRC_EXT 2'h3
`define CWC_ILIM_ON_BIT 21
`define CWC_ILIM_LSB 22
`define CWC_DITHER_OFF_BIT 30
`define CWC_CLK_HZ 32'h0EE6_B280
`define CWC_PIN_PER0_MS 100
`define CWC_PIN_PER1_MS 200
`define CWC_PIN_PER2_MS 500
`define CWC_PIN_PER3_MS 1000
`define CWC_BUS_PER0_S 1
`define CWC_BUS_PER1_S 2
`define CWC_BUS_PER2_S 5
`define CWC_BUS_PER3_S 10
`define CWC_ILIM_UA_STEP 78125
`endif

// ---- cwc_ilim_lut.v ----
// Bus current limit code to threshold lookup, registered.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_ilim_lut
(
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire [3:0] code_i,
    output reg [21:0] limit_ua_o
);
    reg [21:0] next_limit_ua;
    reg [3:0] step_cnt;
    // The first three codes double from 78.125 mA; from code 3 on each step adds 312.5 mA.
    // Reserved codes hold the top threshold rather than wrapping to a small one.
    always @*
    begin
        step_cnt = (code_i > 4'hD) ? 4'hC : code_i - 4'h1;
        case (code_i)
            4'h0: next_limit_ua = 22'h01_312D;
            4'h1: next_limit_ua = 22'h02_625A;
            4'h2: next_limit_ua = 22'h04_C4B4;
            default: next_limit_ua = {18'h0_0000, step_cnt} * 22'h04_C4B4;
        endcase
    end
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            limit_ua_o <= 22'h00_0000;
        else
            limit_ua_o <= next_limit_ua;
    end
endmodule

// ---- cwc_wdt.v ----
// Watchdog timer with selectable tickle period.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_wdt #(
    parameter [31:0] PIN_P0 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER0_MS,
    parameter [31:0] PIN_P1 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER1_MS,
    parameter [31:0] PIN_P2 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER2_MS,
    parameter [31:0] PIN_P3 = `CWC_CLK_HZ / 1000 * `CWC_PIN_PER3_MS,
    parameter [31:0] BUS_P0 = `CWC_CLK_HZ * `CWC_BUS_PER0_S,
    parameter [31:0] BUS_P1 = `CWC_CLK_HZ * `CWC_BUS_PER1_S,
    parameter [31:0] BUS_P2 = `CWC_CLK_HZ * `CWC_BUS_PER2_S,
    parameter [31:0] BUS_P3 = `CWC_CLK_HZ * `CWC_BUS_PER3_S
)
(
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire enable_i,
    input wire source_i,
    input wire [1:0] period_i,
    input wire tickle_i,
    output reg expire_o
);
    reg [31:0] count;
    reg [31:0] limit;
    always @*
    begin
        case ({source_i, period_i})
            3'b000: limit = BUS_P0;
            3'b001: limit = BUS_P1;
            3'b010: limit = BUS_P2;
            3'b011: limit = BUS_P3;
            3'b100: limit = PIN_P0;
            3'b101: limit = PIN_P1;
            3'b110: limit = PIN_P2;
            default: limit = PIN_P3;
        endcase
    end
    always @(posedge ref_clk_i)
    begin
        expire_o <= 1'b0;
        if (sys_rst_i || !enable_i || tickle_i)
            count <= 32'h0000_0000;
        else if (count >= limit - 32'h0000_0001)
        begin
            count <= 32'h0000_0000;
            expire_o <= 1'b1;
        end
        else
            count <= count + 32'h0000_0001;
    end
endmodule

// ---- cwc_top_monitor.sv ----
// Assertion checker for the clock, watchdog and current limit register slice.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_top_monitor
(
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire pready_o,
    input wire [10:0] ext_ref_khz_o,
    input wire ext_ref_sel_o,
    input wire switching_clock_dither_o,
    input wire ilim_active_o,
    input wire [21:0] ilim_ua_o,
    input wire wdt_fault_o,
    input wire outputs_hiz_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire wr = psel_i & penable_i & pready_o & pwrite_i;
    wire wr_sys = wr & (paddr_i == `CWC_SYS2_ADDR);
    wire wr_peri = wr & (paddr_i == `CWC_PERI1_ADDR);
    reg wdt_on;
    reg latch_mode;
    // The expiry pipeline is several stages deep, so a setting counts only once it has
    // been stable for five cycles.
    reg [9:0] hist;
    always @(posedge ref_clk_i)
        if (sys_rst_i)
            {wdt_on, latch_mode, hist} <= 12'h000;
        else
        begin
            if (wr_sys & pstrb_i[0])
                {wdt_on, latch_mode} <= {pwdata_i[4], pwdata_i[0]};
            hist <= {hist[7:0], wdt_on, latch_mode};
        end
    wire wdt_quiet = (hist & 10'h2AA) == 10'h000 && !wdt_on;
    function [21:0] thr(input [3:0] c);
        thr = c < 3 ? 22'h1_312D << c : (c - 1) * 22'h4_C4B4;
    endfunction
    sequence s_ilim_set;
        wr_peri && pstrb_i[3:2] == 2'h3 && pwdata_i[21] && pwdata_i[25:22] < 4'hE;
    endsequence
    sequence s_wipe;
        wr && paddr_i == `CWC_FAULT_ADDR && pstrb_i[0] && pwdata_i[0] && wdt_quiet;
    endsequence
    AST_EXT_REF: assert property (wr_sys && pstrb_i[0] |->
        ##2 ext_ref_khz_o == 11'h008 << $past(pwdata_i[7:5], 2)) else $error("bad ref kHz");
    AST_EXT_SEL: assert property (wr_sys && pstrb_i[1] |->
        ##2 ext_ref_sel_o == ($past(pwdata_i[10:9], 2) == 2'h3)) else $error("bad ref select");
    AST_DITHER: assert property (wr_peri && pstrb_i[3] |->
        ##2 switching_clock_dither_o == !$past(pwdata_i[30], 2)) else $error("bad dither");
    AST_ILIM_EN: assert property (wr_peri && pstrb_i[2] |->
        ##2 ilim_active_o == $past(pwdata_i[21], 2)) else $error("bad limit enable");
    AST_ILIM_VAL: assert property (s_ilim_set |->
        ##3 ilim_ua_o == thr($past(pwdata_i[25:22], 3))) else $error("bad limit value");
    AST_ILIM_OFF: assert property (!ilim_active_o && !$past(ilim_active_o) |->
        ilim_ua_o == 22'h0) else $error("limit applied while disabled");
    AST_WDT_OFF: assert property (wdt_quiet |-> !$rose(wdt_fault_o))
        else $error("watchdog fault while disabled");
    AST_HIZ_MODE: assert property ((hist & 10'h155) == 10'h000 && !latch_mode
        |-> !$rose(outputs_hiz_o)) else $error("outputs floated in report mode");
    AST_HIZ_FAULT: assert property (outputs_hiz_o |-> wdt_fault_o)
        else $error("outputs floated without fault");
    AST_WIPE: assert property (s_wipe |-> ##2 !outputs_hiz_o)
        else $error("fault wipe did not clear latch");
endmodule
bind cwc_top cwc_top_monitor cwc_top_monitor_inst (.*);

// ---- cwc_tickler.sv ----
// Host-side tickler that pulses the watchdog pin at a commanded spacing.
`timescale 1ns/1ps
module cwc_tickler
(
    input wire ref_clk_i,
    input wire run_i,
    input wire [7:0] gap_i,
    output reg tickle_pin_o
);
    reg [7:0] cnt = 8'h00;
    initial tickle_pin_o = 1'b0;
    // One-cycle pulse each gap; a stopped host keeps the pin low.
    always @(posedge ref_clk_i)
    begin
        cnt <= (!run_i || cnt == gap_i) ? 8'h00 : cnt + 8'h01;
        tickle_pin_o <= run_i && cnt == gap_i;
    end
endmodule

// ---- cwc_top_tb.sv ----
// Self-checking bench for the register slice: fields, watchdog, faults, interrupt.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module cwc_top_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] pa = 12'h000;
    reg [31:0] pwd = 32'h0000_0000;
    reg run = 1'b0;
    reg [7:0] gap = 8'h1D;
    reg [3:0] strb = 4'hF;
    wire tpin, prdy, perr, sel, dith, ilon, fault, hiz, irq;
    wire [31:0] prd;
    wire [10:0] khz;
    wire [21:0] ua;
    logic [31:0] rd;
    logic er;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer i;
    always #2 clk = ~clk;
    cwc_top #(.PIN_P0(32'h14), .PIN_P1(32'h28),
        .BUS_P0(32'h1E), .BUS_P1(32'h3C)) cwc_top_inst (
        .ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(strb), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .tickle_pin_i(tpin), .ext_ref_khz_o(khz), .ext_ref_sel_o(sel),
        .switching_clock_dither_o(dith), .ilim_active_o(ilon), .ilim_ua_o(ua),
        .wdt_fault_o(fault), .outputs_hiz_o(hiz), .irq_o(irq));
    cwc_tickler cwc_tickler_inst (.ref_clk_i(clk), .run_i(run), .gap_i(gap),
        .tickle_pin_o(tpin));
    function [21:0] thr(input [3:0] c);
        thr = c < 3 ? 22'h1_312D << c : (c - 1) * 22'h4_C4B4;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (prdy !== 1'b1);
        {rd, er} = {prd, perr};
        {psel, pen} <= 2'b00;
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task tally_and_finish;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #40000;
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(0, `CWC_SYS2_ADDR, 0);
        chk(rd, `CWC_SYS2_RST);
        apb(0, `CWC_PERI1_ADDR, 0);
        chk(rd, `CWC_PERI1_RST);
        chk({dith, khz}, 12'h008);
        for (i = 0; i < 8; i++)
        begin
            apb(1, `CWC_SYS2_ADDR, {21'h0, i[1:0], 1'b0, i[2:0], 5'h0});
            idle(2);
            chk(khz, 11'h008 << i);
            chk(sel, i[1:0] == 2'h3);
        end
        for (i = 0; i < 14; i++)
        begin
            apb(1, `CWC_PERI1_ADDR, {6'h0, i[3:0], 22'h20_0000});
            idle(3);
            chk(ua, thr(i[3:0]));
            chk({ilon, dith}, 2'h3);
        end
        apb(1, `CWC_PERI1_ADDR, 32'hFC5F_FFFF);
        idle(3);
        chk({ilon, dith, ua}, 0);
        apb(0, `CWC_PERI1_ADDR, 0);
        chk(rd, 32'hFC5F_FFFF);
        strb <= 4'h4;
        apb(1, `CWC_PERI1_ADDR, 0);
        strb <= 4'hF;
        apb(0, `CWC_PERI1_ADDR, 0);
        chk(rd, 32'hFC00_FFFF);
        apb(0, 12'h3F0, 0);
        chk({31'h0, er}, 1);
        chk(rd, 0);
        $display("Test of configuration fields done");
        apb(1, `CWC_IRQ_MASK_ADDR, 1);
        apb(1, `CWC_SYS2_ADDR, 32'h2);
        idle(60);
        chk(fault, 0);
        run <= 1'b1;
        apb(1, `CWC_SYS2_ADDR, 32'h16);
        idle(150);
        chk(fault, 0);
        apb(1, `CWC_SYS2_ADDR, 32'h12);
        idle(40);
        run <= 1'b0;
        chk({irq, fault, hiz}, 3'h6);
        apb(1, `CWC_IRQ_MASK_ADDR, 0);
        idle(2);
        chk(irq, 0);
        apb(1, `CWC_IRQ_MASK_ADDR, 1);
        apb(1, `CWC_SYS2_ADDR, 0);
        idle(6);
        apb(1, `CWC_IRQ_STAT_ADDR, 1);
        idle(3);
        chk({irq, fault, hiz}, 0);
        $display("Test of pin watchdog done");
        gap <= 8'h09;
        apb(1, `CWC_SYS2_ADDR, 32'h15);
        repeat (6)
        begin
            apb(1, `CWC_TICKLE_ADDR, 0);
            idle(40);
        end
        chk(fault, 0);
        run <= 1'b1;
        idle(80);
        chk({hiz, fault}, 2'h3);
        apb(0, `CWC_FAULT_ADDR, 0);
        chk(rd[1], 1);
        run <= 1'b0;
        apb(1, `CWC_SYS2_ADDR, 0);
        idle(6);
        apb(1, `CWC_FAULT_ADDR, 1);
        apb(1, `CWC_IRQ_STAT_ADDR, 1);
        idle(3);
        chk({hiz, fault}, 0);
        apb(0, `CWC_FAULT_ADDR, 0);
        chk(rd, 0);
        $display("Test of bus watchdog and wipe done");
        tally_and_finish;
    end
endmodule
